// file: rfic_pkg.sv
/*
 Shared constants and types for the reset flag and initial condition block.
 Assumes a single 125 MHz clock domain.
*/
package rfic_pkg;
    localparam int unsigned PC_W = 10;
    localparam int unsigned SP_W = 3;
    localparam int unsigned PA_W = 8;
    localparam int unsigned PB_W = 6;
    localparam int unsigned INT_W = 8;
    localparam int unsigned WDT_W = 16;
    localparam int unsigned TB_W = 16;
    localparam logic [PC_W-1:0] PC_RST = 10'h000;
    localparam logic [SP_W-1:0] SP_ZERO = 3'h0;
    localparam logic [SP_W-1:0] SP_TOP = 3'h7;
    localparam logic [PA_W-1:0] PA_RST = 8'hff;
    localparam logic [PB_W-1:0] PB_RST = 6'h3f;
    localparam logic [INT_W-1:0] INT_RST = 8'h00;
    localparam logic [WDT_W-1:0] WDT_RST = 16'h0000;
    localparam logic [TB_W-1:0] TB_RST = 16'h0000;
    localparam logic [WDT_W-1:0] WDT_ONE = 16'h0001;
    localparam logic [TB_W-1:0] TB_ONE = 16'h0001;
    localparam logic TIMER_OFF = 1'b0;
    localparam logic FLAG_CLR = 1'b0;
    localparam logic FLAG_SET = 1'b1;
    // Reset kind chosen by the arbiter
    typedef enum logic [2:0] {
        RFIC_NONE, RFIC_POR, RFIC_PIN, RFIC_LVR, RFIC_WDT_RUN, RFIC_WDT_SLP
    } rfic_kind_t;
endpackage : rfic_pkg

// file: rfic_src_if.sv
/*
 Interface carrying the prioritised reset decision between modules.
 Assumes both ends run on the same clock.
*/
`timescale 1ns/10ps
interface rfic_src_if;
    import rfic_pkg::*;
    rfic_kind_t kind;
    modport arb (output kind);
    modport use_side (input kind);
endinterface : rfic_src_if

// file: rfic_arb.sv
/*
 Reset source arbiter: synchronises the asynchronous sources and picks
 one reset kind per cycle. Assumes sources are levels or pulses.
*/
`timescale 1ns/10ps
module rfic_arb (
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    input wire logic por_i,
    input wire logic ext_n_i,
    input wire logic lvr_i,
    input wire logic wdt_to_i,
    input wire logic halted_i,
    rfic_src_if.arb src
);
    import rfic_pkg::*;
    logic [1:0] s1_r;
    logic [1:0] s2_r;
    rfic_kind_t kind_nxt;

    // Two-flop synchronisers for pin-driven inputs; the pin is active low
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            s1_r <= 2'h0;
            s2_r <= 2'h0;
        end else begin
            s1_r <= {~ext_n_i, lvr_i};
            s2_r <= s1_r;
        end
    end

    // Power-on wins over everything else
    always_comb begin
        kind_nxt = RFIC_NONE;
        if (por_i || sys_rst_i) begin
            kind_nxt = RFIC_POR;
        end else if (s2_r[1]) begin
            kind_nxt = RFIC_PIN;
        end else if (s2_r[0]) begin
            kind_nxt = RFIC_LVR;
        end else if (wdt_to_i && halted_i) begin
            kind_nxt = RFIC_WDT_SLP;
        end else if (wdt_to_i) begin
            kind_nxt = RFIC_WDT_RUN;
        end
    end

    assign src.kind = kind_nxt;
endmodule : rfic_arb

// file: rfic_top.sv
/*
 Reset flag and initial condition control: applies each reset kind to the
 status flags and to the core, timer and port initial state.
 Assumes core state is loaded from these outputs while a reset pulse shows,
 and that watchdog time-out and halt come from logic on the same clock.
*/
// How it works
// - Running time-out: full reset, time-out flag set, power-down kept.
// - Sleep/idle time-out zeroes only PC, SP and watchdog counter and sets time-out flag.
// - Power-on clears both flags; pin or low-voltage reset keeps both.
// - Sleep/idle watchdog time-out leaves both flags reading one.
// - Power-on disables every interrupt.
// - Power-on clears watchdog and time base; the watchdog then counts.
// - Power-on turns the timer off.
// - Power-on makes all ports inputs with data and direction all ones.
// - Power-on points the stack pointer at the stack top.
// - Pin reset sets the program counter to zero.
// - Running time-out starts a device reset and sets time-out flag.
`timescale 1ns/10ps
module rfic_top (
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    input wire logic por_i,
    input wire logic external_reset_pin_n_i,
    input wire logic low_voltage_reset_i,
    input wire logic wdt_timeout_i,
    input wire logic halted_i,
    input wire logic enter_halt_i,
    input wire logic wdt_clear_i,
    output logic watchdog_timeout_flag_o,
    output logic power_down_flag_o,
    output logic core_reset_o,
    output logic [rfic_pkg::PC_W-1:0] pc_o,
    output logic [rfic_pkg::SP_W-1:0] sp_o,
    output logic pc_sp_load_o,
    output logic [rfic_pkg::INT_W-1:0] int_en_o,
    output logic [rfic_pkg::WDT_W-1:0] watchdog_counter_o,
    output logic [rfic_pkg::TB_W-1:0] time_base_o,
    output logic timer_on_o,
    output logic [rfic_pkg::PA_W-1:0] pa_data_o,
    output logic [rfic_pkg::PA_W-1:0] pa_dir_o,
    output logic [rfic_pkg::PB_W-1:0] pb_data_o,
    output logic [rfic_pkg::PB_W-1:0] pb_dir_o
);
    import rfic_pkg::*;
    rfic_src_if src ();
    logic por_r;
    logic halted_r;
    logic full_nxt;
    logic sleep_hit;

    rfic_arb u_arb (
        .ref_clk_i(ref_clk_i),
        .sys_rst_i(sys_rst_i),
        .por_i(por_r),
        .ext_n_i(external_reset_pin_n_i),
        .lvr_i(low_voltage_reset_i),
        .wdt_to_i(wdt_timeout_i),
        .halted_i(halted_r),
        .src(src)
    );

    // Power-on level and halt state brought in through two flops each
    logic por_s1_r;
    logic hlt_s1_r;
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            por_s1_r <= 1'b1;
            por_r <= 1'b1;
            hlt_s1_r <= 1'b0;
            halted_r <= 1'b0;
        end else begin
            por_s1_r <= por_i;
            por_r <= por_s1_r;
            hlt_s1_r <= halted_i;
            halted_r <= hlt_s1_r;
        end
    end

    // Kinds that reset the whole device, as opposed to the sleep wake case
    assign full_nxt = (src.kind == RFIC_POR) || (src.kind == RFIC_PIN)
        || (src.kind == RFIC_LVR) || (src.kind == RFIC_WDT_RUN);
    assign sleep_hit = (src.kind == RFIC_WDT_SLP);

    // Time-out flag: a reset kind always beats a software clear landing in
    // the same cycle, so a time-out is never lost to a racing clear
    always_ff @(posedge ref_clk_i) begin
        case (src.kind)
            RFIC_POR: begin
                watchdog_timeout_flag_o <= FLAG_CLR;
            end
            RFIC_PIN, RFIC_LVR: begin
                watchdog_timeout_flag_o <= watchdog_timeout_flag_o;
            end
            RFIC_WDT_RUN: begin
                watchdog_timeout_flag_o <= FLAG_SET;
            end
            RFIC_WDT_SLP: begin
                watchdog_timeout_flag_o <= FLAG_SET;
            end
            default: begin
                // Entering halt and clearing the watchdog both drop it
                if (enter_halt_i || wdt_clear_i) begin
                    watchdog_timeout_flag_o <= FLAG_CLR;
                end
            end
        endcase
    end

    // Power-down flag: only power-on and a sleep time-out touch it among
    // the reset kinds; software events apply only in quiet cycles
    always_ff @(posedge ref_clk_i) begin
        case (src.kind)
            RFIC_POR: begin
                power_down_flag_o <= FLAG_CLR;
            end
            RFIC_PIN, RFIC_LVR, RFIC_WDT_RUN: begin
                power_down_flag_o <= power_down_flag_o;
            end
            RFIC_WDT_SLP: begin
                power_down_flag_o <= FLAG_SET;
            end
            default: begin
                // Halt wins over a clear landing in the same cycle
                if (enter_halt_i) begin
                    power_down_flag_o <= FLAG_SET;
                end else if (wdt_clear_i) begin
                    power_down_flag_o <= FLAG_CLR;
                end
            end
        endcase
    end

    // Core reset pulse: high for every cycle a full reset kind is seen
    always_ff @(posedge ref_clk_i) begin
        core_reset_o <= full_nxt;
    end

    // Load strobe: the core takes pc_o and sp_o only while this is high
    always_ff @(posedge ref_clk_i) begin
        pc_sp_load_o <= full_nxt || sleep_hit;
    end

    // Program counter restarts from the lowest address on every kind
    always_ff @(posedge ref_clk_i) begin
        if (full_nxt || sleep_hit) begin
            pc_o <= PC_RST;
        end
    end

    // Stack pointer: top of stack only at power-on, zero for the rest
    always_ff @(posedge ref_clk_i) begin
        if (src.kind == RFIC_POR) begin
            sp_o <= SP_TOP;
        end else if (sleep_hit || full_nxt) begin
            sp_o <= SP_ZERO;
        end
    end

    // Interrupt enables: any full reset masks them, a sleep wake keeps
    // them so the woken code sees the sources it armed before halting
    always_ff @(posedge ref_clk_i) begin
        if (full_nxt) begin
            int_en_o <= INT_RST;
        end
    end

    // Timer switched off by any full reset; a sleep wake leaves it alone
    always_ff @(posedge ref_clk_i) begin
        if (full_nxt) begin
            timer_on_o <= TIMER_OFF;
        end
    end

    // Watchdog counter: cleared at reset, halt and clear, counts after
    always_ff @(posedge ref_clk_i) begin
        if (full_nxt || sleep_hit || wdt_clear_i || enter_halt_i) begin
            watchdog_counter_o <= WDT_RST;
        end else begin
            watchdog_counter_o <= watchdog_counter_o + WDT_ONE;
        end
    end

    // Time base: cleared only at power-on so other resets keep its phase
    always_ff @(posedge ref_clk_i) begin
        if (src.kind == RFIC_POR) begin
            time_base_o <= TB_RST;
        end else begin
            time_base_o <= time_base_o + TB_ONE;
        end
    end

    // Port A goes to input with all ones; held across a sleep wake
    always_ff @(posedge ref_clk_i) begin
        if (full_nxt) begin
            pa_data_o <= PA_RST;
            pa_dir_o <= PA_RST;
        end
    end

    // Port B likewise, six bits wide
    always_ff @(posedge ref_clk_i) begin
        if (full_nxt) begin
            pb_data_o <= PB_RST;
            pb_dir_o <= PB_RST;
        end
    end
endmodule : rfic_top

// file: rfic_top_assertions.sv
/* Checker for the reset flag block ports.
   Assumes one clock and a synchronous reset. */
`timescale 1ns/10ps
module rfic_top_assertions
    import rfic_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    input wire logic por_i,
    input wire logic external_reset_pin_n_i,
    input wire logic low_voltage_reset_i,
    input wire logic wdt_timeout_i,
    input wire logic halted_i,
    input wire logic watchdog_timeout_flag_o,
    input wire logic power_down_flag_o,
    input wire logic core_reset_o,
    input wire logic pc_sp_load_o,
    input wire logic timer_on_o,
    input wire logic [rfic_pkg::PC_W-1:0] pc_o,
    input wire logic [rfic_pkg::SP_W-1:0] sp_o,
    input wire logic [rfic_pkg::INT_W-1:0] int_en_o,
    input wire logic [rfic_pkg::WDT_W-1:0] watchdog_counter_o,
    input wire logic [rfic_pkg::TB_W-1:0] time_base_o,
    input wire logic [rfic_pkg::PA_W-1:0] pa_data_o,
    input wire logic [rfic_pkg::PA_W-1:0] pa_dir_o,
    input wire logic [rfic_pkg::PB_W-1:0] pb_data_o,
    input wire logic [rfic_pkg::PB_W-1:0] pb_dir_o
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (sys_rst_i);
    // Four quiet samples so the synchronisers hold settled values
    sequence hit_s(h);
        (!por_i && external_reset_pin_n_i && !low_voltage_reset_i &&
         halted_i == h)[*4] ##0 wdt_timeout_i;
    endsequence
    wdt_run_a: assert property (hit_s(1'b0) |=>
        watchdog_timeout_flag_o && core_reset_o && $stable(power_down_flag_o))
        else $error("running timeout wrong");
    wdt_sleep_a: assert property (hit_s(1'b1) |=>
        watchdog_timeout_flag_o && power_down_flag_o && pc_sp_load_o &&
        pc_o == PC_RST && sp_o == SP_ZERO && !core_reset_o)
        else $error("sleep timeout wrong");
    por_flags_a: assert property (por_i[*4] |->
        !watchdog_timeout_flag_o && !power_down_flag_o && core_reset_o)
        else $error("power-on flags wrong");
    por_core_a: assert property (por_i[*4] |->
        int_en_o == INT_RST && timer_on_o == TIMER_OFF && sp_o == SP_TOP)
        else $error("power-on core state wrong");
    por_port_a: assert property (por_i[*4] |->
        pa_data_o == PA_RST && pa_dir_o == PA_RST &&
        pb_data_o == PB_RST && pb_dir_o == PB_RST)
        else $error("power-on ports wrong");
    por_count_a: assert property (por_i[*4] |->
        watchdog_counter_o == WDT_RST && time_base_o == TB_RST)
        else $error("power-on counters wrong");
    pin_keep_a: assert property (
        (!por_i && !external_reset_pin_n_i)[*4] |->
        core_reset_o && pc_o == PC_RST && $stable(power_down_flag_o) &&
        $stable(watchdog_timeout_flag_o))
        else $error("pin reset wrong");
    lvr_keep_a: assert property (
        (!por_i && low_voltage_reset_i)[*4] |->
        core_reset_o && $stable({watchdog_timeout_flag_o, power_down_flag_o}))
        else $error("low voltage reset wrong");
endmodule : rfic_top_assertions
bind rfic_top rfic_top_assertions chk_i (.*);

// file: rfic_src_model.sv
/* Reset source model: turns bench requests into source levels.
   Assumes requests change just after a clock edge. */
`timescale 1ns/10ps
module rfic_src_model (
    input wire logic [4:0] req_i,
    output logic por_o,
    output logic ext_n_o,
    output logic lvr_o,
    output logic wdt_o,
    output logic halted_o
);
    // Pin idles high as if pulled up; only a request pulls it low
    assign ext_n_o = !req_i[1];
    assign {halted_o, wdt_o, lvr_o, por_o} = {req_i[4:2], req_i[0]};
endmodule : rfic_src_model

// file: rfic_top_bench.sv
/* Bench for the reset flag block: walks every reset kind.
   Assumes the source model and checker are compiled first. */
`timescale 1ns/10ps
module rfic_top_bench;
    import rfic_pkg::*;
    logic ref_clk_i, sys_rst_i, por_i, external_reset_pin_n_i, halted_i;
    logic low_voltage_reset_i, wdt_timeout_i, enter_halt_i, wdt_clear_i;
    logic watchdog_timeout_flag_o, power_down_flag_o, core_reset_o;
    logic pc_sp_load_o, timer_on_o;
    logic [PC_W-1:0] pc_o;
    logic [SP_W-1:0] sp_o;
    logic [INT_W-1:0] int_en_o;
    logic [WDT_W-1:0] watchdog_counter_o;
    logic [TB_W-1:0] time_base_o;
    logic [PA_W-1:0] pa_data_o, pa_dir_o;
    logic [PB_W-1:0] pb_data_o, pb_dir_o;
    logic [6:0] drv = 7'h00;
    int mismatches = 0;
    int compares = 0;
    rfic_top DUT (.*);
    rfic_src_model src (.req_i(drv[4:0]), .por_o(por_i),
        .ext_n_o(external_reset_pin_n_i), .lvr_o(low_voltage_reset_i),
        .wdt_o(wdt_timeout_i), .halted_o(halted_i));
    assign {wdt_clear_i, enter_halt_i} = drv[6:5];
    initial begin
        ref_clk_i = 1'b0;
        forever #4 ref_clk_i = ~ref_clk_i;
    end
    task step(input int n);
        repeat (n) @(posedge ref_clk_i);
    endtask : step
    task chk(input logic [15:0] g, input logic [15:0] e);
        compares++;
        if (g !== e) begin
            mismatches++;
            $display("BAD %0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    task flg(input logic t, input logic p);
        chk(16'(watchdog_timeout_flag_o), 16'(t));
        chk(16'(power_down_flag_o), 16'(p));
    endtask : flg
    // Levels stay five edges so both synchroniser flops see them
    task hold(input logic [6:0] m);
        step(1);
        drv <= m;
        step(5);
        #1;
    endtask : hold
    task pulse(input logic [6:0] m);
        step(1);
        drv <= drv | m;
        step(1);
        drv <= drv & ~m;
        // Return just after the sampling edge: pulse outputs stand one cycle
        #1;
    endtask : pulse
    task por_scn();
        hold(7'h07);
        flg(1'b0, 1'b0);
        chk(16'(sp_o), 16'(SP_TOP));
        chk(16'(int_en_o), 16'(INT_RST));
        chk(16'(timer_on_o), 16'(TIMER_OFF));
        chk({pa_data_o, pa_dir_o}, {PA_RST, PA_RST});
        chk(16'({pb_data_o, pb_dir_o}), 16'({PB_RST, PB_RST}));
        chk(time_base_o, TB_RST);
        hold(7'h00);
        chk(16'(watchdog_counter_o != WDT_RST), 16'h0001);
    endtask : por_scn
    task slp_scn();
        pulse(7'h20);
        flg(1'b0, 1'b1);
        hold(7'h10);
        pulse(7'h08);
        flg(1'b1, 1'b1);
        chk(16'({pc_o, sp_o, pc_sp_load_o, core_reset_o}), 16'h0002);
        hold(7'h00);
    endtask : slp_scn
    task keep_scn();
        for (int i = 1; i < 3; i++) begin
            hold(7'(1 << i));
            flg(1'b1, 1'b1);
            chk(16'({pc_o, core_reset_o}), 16'h0001);
            hold(7'h00);
        end
    endtask : keep_scn
    task run_scn();
        pulse(7'h08);
        flg(1'b1, 1'b1);
        pulse(7'h40);
        flg(1'b0, 1'b0);
        pulse(7'h08);
        flg(1'b1, 1'b0);
        chk(16'(core_reset_o), 16'h0001);
    endtask : run_scn
    task stop_test();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : stop_test
    // Hang guard: far beyond the longest sequence below
    initial begin
        #100000;
        mismatches++;
        stop_test();
    end
    initial begin
        sys_rst_i = 1'b1;
        step(8);
        sys_rst_i <= 1'b0;
        step(3);
        por_scn();
        slp_scn();
        keep_scn();
        run_scn();
        stop_test();
    end
endmodule : rfic_top_bench
